// ===== pkg/ptc_cfg.svh
// constants for the periodic timer capture block
// assumes inclusion by bare name from the package and design files
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH
`define PTC_CNT_W 10
`define PTC_ADDR_W 4
`define PTC_DATA_W 16
`define PTC_OFF_CTRL0 4'h0
`define PTC_OFF_CTRL1 4'h1
`define PTC_OFF_PERIOD 4'h2
`define PTC_OFF_CAPTURE 4'h3
`define PTC_OFF_COUNT 4'h4
`define PTC_OFF_FLAGS 4'h5
`define PTC_C0_RUN_BIT 3
`define PTC_C0_CKSEL_LSB 4
`define PTC_C0_PAUSE_BIT 7
`define PTC_C1_SRC_BIT 0
`define PTC_C1_EDGE_LSB 4
`define PTC_C1_MODE_LSB 6
`define PTC_FL_CAP_BIT 0
`define PTC_FL_PER_BIT 1
`define PTC_FL_PIN_BIT 2
`define PTC_RST_CTRL 8'h00
`define PTC_RST_CNT 10'h000
`define PTC_DIV4 8'h04
`define PTC_DIV16 8'h10
`define PTC_DIV64 8'h40
`define PTC_DIVSUB 8'hfa
`endif

// ===== pkg/ptc_pkg.sv
// types for the periodic timer capture block
// assumes ptc_cfg.svh on the include path
`include "ptc_cfg.svh"
package ptc_pkg;
   typedef enum logic [1:0] {
      PTC_MODE_CMP = 2'b00,
      PTC_MODE_CAP = 2'b01,
      PTC_MODE_PWM = 2'b10,
      PTC_MODE_TMR = 2'b11
   } ptc_mode_type;
   typedef enum logic [1:0] {
      PTC_EDGE_RISE = 2'b00,
      PTC_EDGE_FALL = 2'b01,
      PTC_EDGE_BOTH = 2'b10,
      PTC_EDGE_OFF = 2'b11
   } ptc_edge_type;
   typedef logic [`PTC_CNT_W-1:0] ptc_count_type;
endpackage

// ===== design/ptc_tick_gen.sv
// counter clock tick generator: selects one prescaled source or one pin edge
// assumes pin_edge pulses come from already-synchronised pin logic
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_tick_gen (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [2:0] sel,
   input wire logic pin_rise,
   input wire logic pin_fall,
   output logic tick
);
   logic [7:0] div_q;
   logic [7:0] lim;
   always_comb begin
      case (sel)
         3'h0: lim = `PTC_DIV4;
         3'h1: lim = 8'h01;
         3'h2: lim = `PTC_DIV16;
         3'h3: lim = `PTC_DIV64;
         default: lim = `PTC_DIVSUB;
      endcase
   end
   // reset on wrap so a narrower selection never waits for a wide count
   always_ff @(posedge clk) begin
      if (rst) begin
         div_q <= 8'h00;
      end else if (ce) begin
         if (div_q >= lim - 8'h01) begin
            div_q <= 8'h00;
         end else begin
            div_q <= div_q + 8'h01;
         end
      end
   end
   always_comb begin
      case (sel)
         3'h6: tick = pin_rise;
         3'h7: tick = pin_fall;
         default: tick = (div_q >= lim - 8'h01);
      endcase
   end
endmodule

// ===== design/ptc_edge_det.sv
// two-stage synchroniser and edge detector for the capture pin
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
module ptc_edge_det (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else if (ce) begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign level = s2_q;
   assign rise = ce & s2_q & ~s3_q;
   assign fall = ce & ~s2_q & s3_q;
endmodule

// ===== design/ptc_timer.sv
// 10-bit periodic timer in capture-input mode with a plain register port
// assumes a single clk domain; capture pin is asynchronous
//
// Overview of operation
// - counting starts when run enable rises
// - valid edge latches count, sets capture flag
// - capture never stops or clears counter
// - period match returns counter to zero
// - period match sets period-match flag
// - period zero gives full 400H modulus
// - flags stay set until software clears
// - run enable off then on restarts zero
// - mode field 01 selects capture behaviour
// - edge field picks rise, fall, both, none
// - capture disabled still lets counter run
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic capture_input_pin,
   input wire logic [`PTC_ADDR_W-1:0] addr,
   input wire logic [`PTC_DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [`PTC_DATA_W-1:0] rdata,
   output logic capture_irq,
   output logic period_irq
);
   import ptc_pkg::*;

   logic [7:0] ctrl0_q;
   logic [7:0] ctrl1_q;
   ptc_count_type period_compare_reg_q;
   ptc_count_type capture_value_reg_q;
   ptc_count_type count_q;
   logic capture_event_flag_q;
   logic period_match_flag_q;
   logic [`PTC_DATA_W-1:0] rdata_q;
   logic capture_irq_q;
   logic period_irq_q;

   logic count_run_enable;
   logic pause;
   logic capture_source_select;
   ptc_mode_type operating_mode_field;
   ptc_edge_type edge_select_field;
   logic pin_level;
   logic pin_rise;
   logic pin_fall;
   logic tick;
   logic edge_ok;
   logic cap_ev;
   logic per_ev;
   logic wr_flags;

   assign count_run_enable = ctrl0_q[`PTC_C0_RUN_BIT];
   assign pause = ctrl0_q[`PTC_C0_PAUSE_BIT];
   assign capture_source_select = ctrl1_q[`PTC_C1_SRC_BIT];
   assign operating_mode_field = ptc_mode_type'(ctrl1_q[`PTC_C1_MODE_LSB +: 2]);
   assign edge_select_field = ptc_edge_type'(ctrl1_q[`PTC_C1_EDGE_LSB +: 2]);

   ptc_edge_det u_edge (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .pin(capture_input_pin),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   ptc_tick_gen u_tick (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .sel(ctrl0_q[`PTC_C0_CKSEL_LSB +: 3]),
      .pin_rise(pin_rise),
      .pin_fall(pin_fall),
      .tick(tick)
   );

   // compare against the wrap point; zero period means the full range
   function automatic logic at_period(input ptc_count_type cnt, input ptc_count_type per);
      if (per == `PTC_RST_CNT) begin
         at_period = (cnt == {`PTC_CNT_W{1'b1}});
      end else begin
         at_period = (cnt == per);
      end
   endfunction

   always_comb begin
      case (edge_select_field)
         PTC_EDGE_RISE: edge_ok = pin_rise;
         PTC_EDGE_FALL: edge_ok = pin_fall;
         PTC_EDGE_BOTH: edge_ok = pin_rise | pin_fall;
         PTC_EDGE_OFF: edge_ok = 1'b0;
         default: edge_ok = 1'b0;
      endcase
   end

   // source bit is honoured: with no pin source selected nothing triggers
   assign cap_ev = count_run_enable & (operating_mode_field == PTC_MODE_CAP)
      & capture_source_select & edge_ok;
   assign per_ev = count_run_enable & ~pause & tick
      & at_period(count_q, period_compare_reg_q);
   assign wr_flags = wr & (addr == `PTC_OFF_FLAGS);

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl0_q <= `PTC_RST_CTRL;
         ctrl1_q <= `PTC_RST_CTRL;
         period_compare_reg_q <= `PTC_RST_CNT;
      end else if (ce && wr) begin
         case (addr)
            `PTC_OFF_CTRL0: ctrl0_q <= wdata[7:0];
            `PTC_OFF_CTRL1: ctrl1_q <= wdata[7:0];
            `PTC_OFF_PERIOD: period_compare_reg_q <= wdata[`PTC_CNT_W-1:0];
            default: ;
         endcase
      end
   end

   // counter: edges never disturb it, only run enable and the period wrap
   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= `PTC_RST_CNT;
      end else if (ce) begin
         if (!count_run_enable) begin
            count_q <= `PTC_RST_CNT;
         end else if (per_ev) begin
            count_q <= `PTC_RST_CNT;
         end else if (tick && !pause) begin
            count_q <= count_q + 10'h001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         capture_value_reg_q <= `PTC_RST_CNT;
      end else if (ce && cap_ev) begin
         capture_value_reg_q <= count_q;
      end
   end

   // write one to clear; a same-cycle event wins over the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         capture_event_flag_q <= 1'b0;
         period_match_flag_q <= 1'b0;
      end else if (ce) begin
         if (cap_ev) begin
            capture_event_flag_q <= 1'b1;
         end else if (wr_flags && wdata[`PTC_FL_CAP_BIT]) begin
            capture_event_flag_q <= 1'b0;
         end
         if (per_ev) begin
            period_match_flag_q <= 1'b1;
         end else if (wr_flags && wdata[`PTC_FL_PER_BIT]) begin
            period_match_flag_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         capture_irq_q <= 1'b0;
         period_irq_q <= 1'b0;
      end else if (ce) begin
         capture_irq_q <= capture_event_flag_q | cap_ev;
         period_irq_q <= period_match_flag_q | per_ev;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (ce) begin
         rdata_q <= '0;
         if (rd) begin
            case (addr)
               `PTC_OFF_CTRL0: rdata_q <= {8'h00, ctrl0_q};
               `PTC_OFF_CTRL1: rdata_q <= {8'h00, ctrl1_q};
               `PTC_OFF_PERIOD: rdata_q <= {6'h00, period_compare_reg_q};
               `PTC_OFF_CAPTURE: rdata_q <= {6'h00, capture_value_reg_q};
               `PTC_OFF_COUNT: rdata_q <= {6'h00, count_q};
               // pin level lets software tell which edge ended the pulse
               `PTC_OFF_FLAGS: rdata_q <= {13'h0000, pin_level, period_match_flag_q,
                  capture_event_flag_q};
               default: rdata_q <= '0;
            endcase
         end
      end
   end

   assign rdata = rdata_q;
   assign capture_irq = capture_irq_q;
   assign period_irq = period_irq_q;

   chk_capture_latches: assert property (@(posedge clk) disable iff (rst)
      ce && cap_ev |=> capture_value_reg_q == $past(count_q) && capture_event_flag_q)
      else $error("capture did not latch count");
   chk_edge_keeps_count: assert property (@(posedge clk) disable iff (rst)
      ce && cap_ev && !tick && count_run_enable |=> count_q == $past(count_q))
      else $error("capture disturbed counter");
   chk_period_wrap: assert property (@(posedge clk) disable iff (rst)
      ce && per_ev |=> count_q == 10'h000 && period_match_flag_q)
      else $error("period match did not wrap");
   chk_full_range: assert property (@(posedge clk) disable iff (rst)
      ce && count_run_enable && period_compare_reg_q == 10'h000 && count_q == 10'h3ff
      && tick && !pause |-> per_ev)
      else $error("full range wrap missing");
   chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
      capture_event_flag_q && !(ce && wr_flags && wdata[`PTC_FL_CAP_BIT]) |=>
      capture_event_flag_q)
      else $error("capture flag dropped");
   chk_idle_zero: assert property (@(posedge clk) disable iff (rst)
      ce && !count_run_enable |=> count_q == 10'h000)
      else $error("counter not held at zero");
   chk_run_counts: assert property (@(posedge clk) disable iff (rst)
      ce && count_run_enable && tick && !pause && !per_ev |=>
      count_q == $past(count_q) + 10'h001)
      else $error("counter did not step");
   chk_disabled_edge: assert property (@(posedge clk) disable iff (rst)
      edge_select_field == PTC_EDGE_OFF |=> $stable(capture_value_reg_q))
      else $error("capture while disabled");
   chk_mode_gate: assert property (@(posedge clk) disable iff (rst)
      operating_mode_field != PTC_MODE_CAP |=> $stable(capture_value_reg_q))
      else $error("capture outside capture mode");
   chk_capture_hold: assert property (@(posedge clk) disable iff (rst)
      !(ce && cap_ev) |=> $stable(capture_value_reg_q))
      else $error("capture value moved without an edge");
   chk_period_sticky: assert property (@(posedge clk) disable iff (rst)
      period_match_flag_q && !(ce && wr_flags && wdata[`PTC_FL_PER_BIT]) |=>
      period_match_flag_q)
      else $error("period flag dropped");
   chk_flag_clears: assert property (@(posedge clk) disable iff (rst)
      ce && wr_flags && wdata[`PTC_FL_CAP_BIT] && !cap_ev |=> !capture_event_flag_q)
      else $error("capture flag not cleared");
   chk_cap_irq: assert property (@(posedge clk) disable iff (rst)
      ce && capture_event_flag_q |=> capture_irq_q)
      else $error("capture request missing");
   chk_per_irq: assert property (@(posedge clk) disable iff (rst)
      ce && period_match_flag_q |=> period_irq_q)
      else $error("period request missing");
   chk_idle_no_flag: assert property (@(posedge clk) disable iff (rst)
      ce && !count_run_enable && !capture_event_flag_q && !period_match_flag_q |=>
      !capture_event_flag_q && !period_match_flag_q)
      else $error("flag set while stopped");
   chk_rise_only: assert property (@(posedge clk) disable iff (rst)
      ce && edge_select_field == PTC_EDGE_RISE && !pin_rise && !capture_event_flag_q |=>
      !capture_event_flag_q)
      else $error("capture on a non-rising edge");
   chk_fall_only: assert property (@(posedge clk) disable iff (rst)
      ce && edge_select_field == PTC_EDGE_FALL && !pin_fall && !capture_event_flag_q |=>
      !capture_event_flag_q)
      else $error("capture on a non-falling edge");
   // a period rewrite may leave the count above the new limit, so it is excluded
   chk_period_bound: assert property (@(posedge clk) disable iff (rst)
      ce && count_run_enable && period_compare_reg_q != 10'h000
      && count_q <= period_compare_reg_q && !(wr && addr == `PTC_OFF_PERIOD) |=>
      count_q <= period_compare_reg_q)
      else $error("count passed the period");
   chk_pause_freeze: assert property (@(posedge clk) disable iff (rst)
      ce && count_run_enable && pause |=> $stable(count_q))
      else $error("count moved while paused");
   cov_capture: cover property (@(posedge clk) disable iff (rst)
      ce && cap_ev);
   cov_wrap: cover property (@(posedge clk) disable iff (rst)
      ce && per_ev);
   cov_both: cover property (@(posedge clk) disable iff (rst)
      cap_ev && edge_select_field == PTC_EDGE_BOTH && pin_fall);
   cov_pause: cover property (@(posedge clk) disable iff (rst)
      ce && count_run_enable && pause);
   cov_restart: cover property (@(posedge clk) disable iff (rst)
      $rose(count_run_enable));
endmodule

// ===== verification/ptc_pulse_src.sv
// pulse source model driving the capture pin
// assumes the bench asks for a level; changes land just after a clk edge
`timescale 1ns/1ps
module ptc_pulse_src #(
   parameter int MIN_HOLD = 20
) (
   input wire logic clk,
   input wire logic want,
   output logic pin
);
   int held = 0;
   logic lv_q = 1'b0;
   assign pin = lv_q;
   // a level is never cut shorter than the minimum pulse, so a hasty request waits
   always @(posedge clk) begin
      if (want !== lv_q && held >= MIN_HOLD) begin
         lv_q <= want;
         held <= 0;
      end else begin
         held <= held + 1;
      end
   end
endmodule

// ===== verification/ptc_timer_tb.sv
// self-checking bench for the capture timer
// assumes the pulse source model and the register map of the config header
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_timer_tb;
   import ptc_pkg::*;
   logic clk, rst, pin, want, wr, rd, capture_irq, period_irq;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, v, w;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int tp, ta;
   ptc_timer dut_u (.clk(clk), .rst(rst), .ce(1'b1), .capture_input_pin(pin),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .capture_irq(capture_irq), .period_irq(period_irq));
   ptc_pulse_src src_u (.clk(clk), .want(want), .pin(pin));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // the cycle stamp makes expected widths independent of pin sync latency
   task automatic set_pin(input logic lv, input int n);
      @(posedge clk);
      want <= lv;
      tp = cyc;
      repeat (n) @(posedge clk);
   endtask
   task automatic setup(input logic [1:0] e, input logic [15:0] p);
      wreg(`PTC_OFF_CTRL0, 16'h0000);
      wreg(`PTC_OFF_PERIOD, p);
      wreg(`PTC_OFF_CTRL1, 16'h0041 | {10'h000, e, 4'h0});
      wreg(`PTC_OFF_CTRL0, 16'h0018);
      wreg(`PTC_OFF_FLAGS, 16'h0003);
   endtask
   task automatic t_idle();
      wreg(`PTC_OFF_CTRL1, 16'h0061);
      set_pin(1'b1, 40);
      set_pin(1'b0, 40);
      rreg(`PTC_OFF_COUNT, v);
      chk(v, 16'h0000);
      rreg(`PTC_OFF_FLAGS, v);
      chk(v & 16'h0003, 16'h0000);
   endtask
   task automatic t_edges();
      for (int i = 0; i < 4; i++) begin
         setup(i[1:0], 16'h0000);
         set_pin(1'b1, 40);
         rreg(`PTC_OFF_FLAGS, v);
         chk({15'h0000, v[0]}, {15'h0000, (i == 0 || i == 2)});
         chk({15'h0000, capture_irq}, {15'h0000, (i == 0 || i == 2)});
         wreg(`PTC_OFF_FLAGS, 16'h0001);
         rreg(`PTC_OFF_FLAGS, v);
         chk({15'h0000, v[0]}, 16'h0000);
         set_pin(1'b0, 40);
         rreg(`PTC_OFF_FLAGS, v);
         chk({15'h0000, v[0]}, {15'h0000, (i == 1 || i == 2)});
         rreg(`PTC_OFF_COUNT, v);
         rreg(`PTC_OFF_COUNT, w);
         chk({15'h0000, v !== w}, 16'h0001);
      end
   endtask
   task automatic t_width();
      int tf;
      setup(PTC_EDGE_BOTH, 16'h0000);
      set_pin(1'b1, 400);
      ta = tp;
      rreg(`PTC_OFF_CAPTURE, v);
      rreg(`PTC_OFF_FLAGS, w);
      chk(w & 16'h0005, 16'h0005);
      wreg(`PTC_OFF_FLAGS, 16'h0001);
      // the low pulse carries the count past 3ff while each width stays below 1024
      set_pin(1'b0, 700);
      tf = tp;
      rreg(`PTC_OFF_FLAGS, w);
      chk(w & 16'h0005, 16'h0001);
      rreg(`PTC_OFF_CAPTURE, w);
      chk((w - v) & 16'h03ff, 16'(tf - ta));
      v = w;
      set_pin(1'b1, 20);
      rreg(`PTC_OFF_CAPTURE, w);
      chk({15'h0000, (w <= v)}, 16'h0001);
      if (w > v) begin
         w = w - v;
      end else begin
         w = w + 16'h0400 - v;
      end
      chk(w, 16'(tp - tf));
      rreg(`PTC_OFF_FLAGS, v);
      chk({15'h0000, v[1]}, 16'h0001);
      chk({15'h0000, period_irq}, 16'h0001);
   endtask
   task automatic t_period();
      setup(PTC_EDGE_OFF, 16'h0009);
      set_pin(1'b0, 30);
      rreg(`PTC_OFF_FLAGS, v);
      chk(v & 16'h0003, 16'h0002);
      for (int k = 0; k < 12; k++) begin
         rreg(`PTC_OFF_COUNT, v);
         chk({15'h0000, v <= 16'h0009}, 16'h0001);
      end
   endtask
   task automatic t_restart();
      int tr, tf;
      wreg(`PTC_OFF_PERIOD, 16'h0000);
      wreg(`PTC_OFF_CTRL1, 16'h0061);
      wreg(`PTC_OFF_CTRL0, 16'h0000);
      rreg(`PTC_OFF_COUNT, v);
      chk(v, 16'h0000);
      wreg(`PTC_OFF_CTRL0, 16'h0018);
      rreg(`PTC_OFF_COUNT, v);
      chk({15'h0000, v < 16'h0008}, 16'h0001);
      wreg(`PTC_OFF_CTRL0, 16'h0098);
      rreg(`PTC_OFF_COUNT, v);
      rreg(`PTC_OFF_COUNT, w);
      chk(w, v);
      // samples 40 cycles apart see exactly ten ticks of the /4 clock
      wreg(`PTC_OFF_CTRL0, 16'h0008);
      rreg(`PTC_OFF_COUNT, v);
      repeat (38) @(posedge clk);
      rreg(`PTC_OFF_COUNT, w);
      chk(w - v, 16'h000a);
      // restart after the rising edge only; software adds the cycles its restart cost
      wreg(`PTC_OFF_CTRL0, 16'h0018);
      set_pin(1'b1, 30);
      ta = tp;
      wreg(`PTC_OFF_CTRL0, 16'h0000);
      wreg(`PTC_OFF_CTRL0, 16'h0018);
      tr = cyc;
      set_pin(1'b0, 30);
      tf = tp;
      rreg(`PTC_OFF_CAPTURE, v);
      // correction runs from the rising capture to the first count after restart
      chk(v + 16'(tr - ta - 3), 16'(tf - ta));
   endtask
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      want = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_idle();
      t_edges();
      t_width();
      t_period();
      t_restart();
      report_and_stop();
   end
endmodule
